/* hw/rgbled_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// RULE1 - All LED outputs go off while the supply is below the lockout level.
// RULE2 - After a lockout the outputs stay off until the host writes again.
// RULE3 - With only the red resistor fitted the colour codes scale each group.
// RULE4 - With a resistor on every colour reference the codes have no effect.
// RULE5 - Reset pin low: outputs off, registers held cleared, writes ignored.
// RULE6 - Reset pin high: outputs may drive current and writes are accepted.
// RULE7 - Registers clear at power-up only when the supply ramps from zero.
// RULE8 - The host waits at least 3 ms after the protection supply is up; the testbench host waits only 8 clock cycles.
// RULE9 - Three consecutive colour registers each hold a 5-bit current code.
// RULE10 - Three registers hold one full-on bit per output, red1 to blue8.
// RULE11 - An output with its full-on bit set is on and its duty is ignored.
// RULE12 - Twenty-four consecutive registers hold each output's duty in order.
// RULE13 - Each duty register is 8 bits wide, giving 256 steps.
// RULE14 - Duty code N keeps the output on for N of every 256 PWM periods; the code keeps it on for N of every 256 clock cycles.
module rgbled_ctrl
    import rgbled_pkg::*;
#(
    parameter int CH = NUM_CH
) (
    input  wire logic              I_CLOCK,
    input  wire logic              I_RST,
    input  wire logic              I_RESET_N,
    input  wire logic              I_UNDERVOLTAGE_LOCKOUT,
    input  wire logic              I_SUPPLY_UP_FROM_ZERO,
    input  wire logic              I_PER_COLOUR_REF,
    input  wire rgbled_req_t       I_REQ,
    output var  logic [7:0]        O_RD_DATA,
    output var  logic              O_RD_VALID,
    output var  logic              O_LED_OUTPUTS_EN,
    output var  logic [CH-1:0]     O_LED_OUTPUTS,
    output var  rgbled_cur_t       O_CUR
);

    ////////////////////////////////////////////////////////////////////////
    // Address decode

    function automatic logic is_duty(input logic [7:0] a);
        is_duty = (a >= DUTY_R1_OFS) && (a <= DUTY_B8_OFS);
    endfunction

    function automatic logic is_full(input logic [7:0] a);
        is_full = (a >= FULL_ON0_OFS) && (a <= FULL_ON2_OFS);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Register file

    logic [4:0]        cur_q  [3];
    logic [4:0]        cur_d  [3];
    logic [CH-1:0]     full_q;
    logic [CH-1:0]     full_d;
    logic [7:0]        duty_q [CH];
    logic [7:0]        duty_d [CH];
    logic              wr_acc;
    logic              clr;
    logic [7:0]        duty_idx;
    logic [7:0]        full_idx;

    // Pin low blocks writes; a ramp from zero clears all settings
    assign wr_acc   = I_REQ.wr && I_RESET_N; // RULE5 RULE6
    assign clr      = !I_RESET_N || I_SUPPLY_UP_FROM_ZERO; // RULE5 RULE7
    assign duty_idx = I_REQ.addr - DUTY_R1_OFS;
    assign full_idx = I_REQ.addr - FULL_ON0_OFS;

    always_comb begin
        cur_d  = cur_q;
        full_d = full_q;
        duty_d = duty_q;
        if (clr) begin
            for (int i = 0; i < 3; i++) begin
                cur_d[i] = CUR_RST;
            end
            full_d = {(CH/8){FULL_ON_RST}};
            for (int i = 0; i < CH; i++) begin
                duty_d[i] = DUTY_RST;
            end
        end else if (wr_acc) begin
            if (I_REQ.addr <= BLUE_CUR_OFS) begin
                cur_d[I_REQ.addr[1:0]] = I_REQ.data[4:0]; // RULE9
            end else if (is_full(I_REQ.addr)) begin
                full_d[full_idx[1:0]*8 +: 8] = I_REQ.data; // RULE10
            end else if (is_duty(I_REQ.addr)) begin
                duty_d[duty_idx[4:0]] = I_REQ.data; // RULE12 RULE13
            end
        end
    end

    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            for (int i = 0; i < 3; i++) begin
                cur_q[i] <= CUR_RST;
            end
            full_q <= {(CH/8){FULL_ON_RST}};
            for (int i = 0; i < CH; i++) begin
                duty_q[i] <= DUTY_RST;
            end
        end else begin
            cur_q  <= cur_d;
            full_q <= full_d;
            duty_q <= duty_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read path

    logic [7:0] rd_data_d;
    logic       rd_valid_d;

    always_comb begin
        rd_valid_d = I_REQ.rd && I_RESET_N;
        rd_data_d  = RD_UNMAPPED;
        if (I_REQ.addr <= BLUE_CUR_OFS) begin
            rd_data_d = {3'h0, cur_q[I_REQ.addr[1:0]]};
        end else if (is_full(I_REQ.addr)) begin
            rd_data_d = full_q[full_idx[1:0]*8 +: 8];
        end else if (is_duty(I_REQ.addr)) begin
            rd_data_d = duty_q[duty_idx[4:0]];
        end
    end

    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            O_RD_DATA  <= RD_UNMAPPED;
            O_RD_VALID <= 1'b0;
        end else begin
            O_RD_DATA  <= rd_data_d;
            O_RD_VALID <= rd_valid_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Undervoltage lockout

    logic lockout_q;
    logic lockout_d;

    // Latched so a short dip still needs a host rewrite to recover
    always_comb begin
        lockout_d = lockout_q;
        if (I_UNDERVOLTAGE_LOCKOUT) begin
            lockout_d = 1'b1; // RULE1
        end else if (wr_acc) begin
            lockout_d = 1'b0; // RULE2
        end
    end

    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            lockout_q <= 1'b0;
        end else begin
            lockout_q <= lockout_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // PWM and output drive

    logic [7:0]    pwm_cnt_q;
    logic [7:0]    pwm_cnt_d;
    logic          drive_en;
    logic [CH-1:0] led_d;
    rgbled_cur_t   cur_out_d;

    assign pwm_cnt_d = pwm_cnt_q + 8'h01;
    // Set wins: the write that clears lockout also enables drive
    assign drive_en  = I_RESET_N && !I_UNDERVOLTAGE_LOCKOUT
                       && !lockout_d; // RULE1 RULE2 RULE5 RULE6

    generate
        for (genvar g = 0; g < CH; g++) begin : g_ch
            // Full-on bypasses the comparator, so duty is ignored
            assign led_d[g] = drive_en && (full_q[g] // RULE11
                              || (pwm_cnt_q < duty_q[g])); // RULE14
        end
    endgenerate

    always_comb begin
        if (I_PER_COLOUR_REF) begin
            cur_out_d = '{CUR_FULL_SCALE, CUR_FULL_SCALE,
                          CUR_FULL_SCALE}; // RULE4
        end else begin
            cur_out_d = '{cur_q[0], cur_q[1], cur_q[2]}; // RULE3
        end
    end

    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            pwm_cnt_q        <= 8'h00;
            O_LED_OUTPUTS    <= {CH{1'b0}};
            O_LED_OUTPUTS_EN <= 1'b0;
            O_CUR            <= '0;
        end else begin
            pwm_cnt_q        <= pwm_cnt_d;
            O_LED_OUTPUTS    <= led_d;
            O_LED_OUTPUTS_EN <= drive_en;
            O_CUR            <= cur_out_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (I_RST);

    property p_undervoltage_lockout_off;
        I_UNDERVOLTAGE_LOCKOUT |=> (O_LED_OUTPUTS == '0);
    endproperty
    a_undervoltage_lockout_off: assert property (p_undervoltage_lockout_off) // RULE1
        else $error("outputs on during undervoltage");

    property p_stay_off;
        lockout_q && !wr_acc ##1 lockout_q && !wr_acc
            |=> !O_LED_OUTPUTS_EN [*1];
    endproperty
    a_stay_off: assert property (p_stay_off) // RULE2
        else $error("outputs back without a rewrite");

    property p_pin_low;
        !I_RESET_N |=> !O_LED_OUTPUTS_EN && O_LED_OUTPUTS == '0
                       && full_q == '0 && duty_q[0] == DUTY_RST;
    endproperty
    a_pin_low: assert property (p_pin_low) // RULE5
        else $error("reset pin low but device active");

    property p_pin_high;
        I_RESET_N && !I_UNDERVOLTAGE_LOCKOUT && I_REQ.wr
            |=> O_LED_OUTPUTS_EN;
    endproperty
    a_pin_high: assert property (p_pin_high) // RULE6
        else $error("drive not enabled with reset pin high");

    property p_ramp_clear;
        I_SUPPLY_UP_FROM_ZERO |=> cur_q[0] == CUR_RST
                                  && duty_q[CH-1] == DUTY_RST;
    endproperty
    a_ramp_clear: assert property (p_ramp_clear) // RULE7
        else $error("registers not cleared at power-up");

    property p_shared_ref;
        !I_PER_COLOUR_REF |=> O_CUR.green == $past(cur_q[1]);
    endproperty
    a_shared_ref: assert property (p_shared_ref) // RULE3
        else $error("green code not applied");

    property p_own_ref;
        I_PER_COLOUR_REF |=> O_CUR.blue == CUR_FULL_SCALE;
    endproperty
    a_own_ref: assert property (p_own_ref) // RULE4
        else $error("code applied with own resistors");

    property p_duty_wr;
        wr_acc && !clr && I_REQ.addr == DUTY_R1_OFS
            |=> duty_q[0] == $past(I_REQ.data);
    endproperty
    a_duty_wr: assert property (p_duty_wr) // RULE12
        else $error("duty write lost");

    property p_full_on;
        full_q[0] && drive_en |=> O_LED_OUTPUTS[0];
    endproperty
    a_full_on: assert property (p_full_on) // RULE11
        else $error("full-on output not driven");

    property p_duty_zero;
        duty_q[1] == 8'h00 && !full_q[1] |=> !O_LED_OUTPUTS[1];
    endproperty
    a_duty_zero: assert property (p_duty_zero) // RULE14
        else $error("duty zero but output on");

    property p_rd_valid;
        I_REQ.rd && I_RESET_N |=> O_RD_VALID;
    endproperty
    a_rd_valid: assert property (p_rd_valid) // RULE6
        else $error("read not answered with reset pin high");

    property p_rd_refused;
        !I_RESET_N |=> !O_RD_VALID;
    endproperty
    a_rd_refused: assert property (p_rd_refused) // RULE5
        else $error("read answered with reset pin low");

    property p_cur_wr;
        wr_acc && !clr && I_REQ.addr == RED_CUR_OFS
            |=> cur_q[0] == $past(I_REQ.data[4:0]);
    endproperty
    a_cur_wr: assert property (p_cur_wr) // RULE9
        else $error("current code write lost");

    property p_full_lo_wr;
        wr_acc && !clr && I_REQ.addr == FULL_ON0_OFS
            |=> full_q[7:0] == $past(I_REQ.data);
    endproperty
    a_full_lo_wr: assert property (p_full_lo_wr) // RULE10
        else $error("first full-on write lost");

    property p_full_hi_wr;
        wr_acc && !clr && I_REQ.addr == FULL_ON2_OFS
            |=> full_q[CH-1 -: 8] == $past(I_REQ.data);
    endproperty
    a_full_hi_wr: assert property (p_full_hi_wr) // RULE10
        else $error("last full-on write lost");

    property p_duty_last;
        wr_acc && !clr && I_REQ.addr == DUTY_B8_OFS
            |=> duty_q[CH-1] == $past(I_REQ.data);
    endproperty
    a_duty_last: assert property (p_duty_last) // RULE12
        else $error("last duty write lost");

    property p_drive_off;
        !drive_en |=> !O_LED_OUTPUTS_EN && O_LED_OUTPUTS == '0;
    endproperty
    a_drive_off: assert property (p_drive_off) // RULE2
        else $error("outputs on while drive disabled");

    property p_pwm_on;
        drive_en && !full_q[0] && pwm_cnt_q < duty_q[0]
            |=> O_LED_OUTPUTS[0];
    endproperty
    a_pwm_on: assert property (p_pwm_on) // RULE14
        else $error("output off inside duty window");

    property p_pwm_off;
        !full_q[0] && pwm_cnt_q >= duty_q[0] |=> !O_LED_OUTPUTS[0];
    endproperty
    a_pwm_off: assert property (p_pwm_off) // RULE14
        else $error("output on outside duty window");

    property p_cur_rd;
        I_REQ.rd && I_REQ.addr == GREEN_CUR_OFS
            |=> O_RD_DATA == {3'h0, $past(cur_q[1])};
    endproperty
    a_cur_rd: assert property (p_cur_rd) // RULE9
        else $error("current code read wrong");

    property p_unmapped_rd;
        I_REQ.rd && I_REQ.addr > DUTY_B8_OFS |=> O_RD_DATA == RD_UNMAPPED;
    endproperty
    a_unmapped_rd: assert property (p_unmapped_rd) // RULE12
        else $error("unmapped read not zero");

    c_undervoltage_lockout_recover: cover property (lockout_q ##1 !lockout_q);
    c_full_on: cover property (O_LED_OUTPUTS[0] && full_q[0]);
    c_pwm_edge: cover property (!O_LED_OUTPUTS[2] ##1 O_LED_OUTPUTS[2]);
    c_pin_release: cover property (!I_RESET_N ##1 I_RESET_N);
    c_ramp_clear: cover property (I_SUPPLY_UP_FROM_ZERO);

endmodule

`default_nettype wire

/* hw/rgbled_pkg.sv */
package rgbled_pkg;

    localparam int NUM_CH     = 24;
    localparam int CUR_W      = 5;
    localparam int DUTY_W     = 8;
    localparam int ADDR_W     = 8;
    localparam int DATA_W     = 8;

    // Register map
    localparam logic [7:0] RED_CUR_OFS   = 8'h00;
    localparam logic [7:0] GREEN_CUR_OFS = 8'h01;
    localparam logic [7:0] BLUE_CUR_OFS  = 8'h02;
    localparam logic [7:0] FULL_ON0_OFS  = 8'h03;
    localparam logic [7:0] FULL_ON2_OFS  = 8'h05;
    localparam logic [7:0] DUTY_R1_OFS   = 8'h06;
    localparam logic [7:0] DUTY_B8_OFS   = 8'h1D;

    // Reset values
    localparam logic [4:0] CUR_RST       = 5'h00;
    localparam logic [7:0] FULL_ON_RST   = 8'h00;
    localparam logic [7:0] DUTY_RST      = 8'h00;
    localparam logic [7:0] RD_UNMAPPED   = 8'h00;

    // Code driven when every colour has its own reference resistor
    localparam logic [4:0] CUR_FULL_SCALE = 5'h1F;

    // Serial write or read request after deframing
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] data;
    } rgbled_req_t;

    // Per-colour current codes toward the analog drivers
    typedef struct packed {
        logic [4:0] red;
        logic [4:0] green;
        logic [4:0] blue;
    } rgbled_cur_t;

endpackage

/* tb/rgbled_host.sv */
`timescale 1ns/1ps
`default_nettype none
module rgbled_host
    import rgbled_pkg::*;
#(
    parameter int WAIT_CYC = 8
) (
    input  wire logic        i_clock,
    input  wire logic        i_rd_valid,
    input  wire logic [7:0]  i_rd_data,
    output var  rgbled_req_t o_req
);
    initial o_req = '0;
    ////////////////////////////////////////////////////////////////////////
    // Start-up wait, scaled down so the run stays short
    task automatic boot();
        repeat (WAIT_CYC) @(negedge i_clock);
    endtask
    // One request, then an idle cycle so no signal is set twice at once
    task automatic xfer(input logic w, input logic [7:0] a, d,
                        output logic v, output logic [7:0] q);
        o_req <= '{wr: w, rd: !w, addr: a, data: d};
        @(negedge i_clock);
        v = i_rd_valid;
        q = i_rd_data;
        // Idle bus shows inverted values, never the stale request
        o_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, data: ~d};
        @(negedge i_clock);
        if (v !== 1'b1) begin
            v = i_rd_valid;
            q = i_rd_data;
        end
    endtask
endmodule
`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import rgbled_pkg::*;
    logic        clk, rst, rst_n, undervoltage_lockout, pz, pcr, v;
    logic [7:0]  q, rdat;
    logic        rval, en;
    logic [23:0] led;
    rgbled_req_t req;
    rgbled_cur_t cur;
    int          err_count = 0;
    int          num_checks = 0;
    int          n;
    typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} rgbled_row_t;
    rgbled_row_t rows [10] = '{'{8'h00, 8'hFF, 8'h1F}, '{8'h01, 8'h0A, 8'h0A},
        '{8'h02, 8'h15, 8'h15}, '{8'h03, 8'hA5, 8'hA5}, '{8'h04, 8'h5A, 8'h5A},
        '{8'h05, 8'h81, 8'h81}, '{8'h06, 8'h80, 8'h80}, '{8'h1D, 8'hFF, 8'hFF},
        '{8'h1E, 8'h77, 8'h00}, '{8'hFF, 8'h33, 8'h00}};
    ////////////////////////////////////////////////////////////////////////
    rgbled_ctrl #(.CH(NUM_CH)) u_rgbled_ctrl (
        .I_CLOCK(clk), .I_RST(rst), .I_RESET_N(rst_n),
        .I_UNDERVOLTAGE_LOCKOUT(undervoltage_lockout), .I_SUPPLY_UP_FROM_ZERO(pz),
        .I_PER_COLOUR_REF(pcr), .I_REQ(req), .O_RD_DATA(rdat),
        .O_RD_VALID(rval), .O_LED_OUTPUTS_EN(en), .O_LED_OUTPUTS(led),
        .O_CUR(cur));
    rgbled_host u_rgbled_host (.i_clock(clk), .i_rd_valid(rval),
        .i_rd_data(rdat), .o_req(req));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, exp, input string m);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic x(input logic w, input logic [7:0] a, d);
        u_rgbled_host.xfer(w, a, d, v, q);
    endtask
    task automatic cnt(input int ch);
        n = 0;
        repeat (256) begin
            @(negedge clk);
            n += int'(led[ch] === 1'b1);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Whole run is near 1150 cycles; allow plenty of slack
    initial begin
        #40000;
        err_count++;
        summarize();
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {rst, rst_n, undervoltage_lockout, pz, pcr} = 5'b11000;
        repeat (16) @(negedge clk);
        rst = 1'b0;
        u_rgbled_host.boot();
        foreach (rows[i]) begin
            x(1'b0, rows[i].a, 8'h00);
            chk({v, q}, 9'h100, "reset value");
            x(1'b1, rows[i].a, rows[i].d);
            chk(v, 1'b0, "write valid");
            x(1'b0, rows[i].a, 8'h00);
            chk({v, q}, {1'b1, rows[i].e}, "readback");
        end
        $display("register map done");
        chk(cur, {5'h1F, 5'h0A, 5'h15}, "codes");
        pcr = 1'b1;
        repeat (2) @(negedge clk);
        chk(cur, {3{CUR_FULL_SCALE}}, "own refs");
        pcr = 1'b0;
        x(1'b1, 8'h03, 8'h01);
        x(1'b1, 8'h06, 8'h00);
        cnt(0);
        chk(n, 256, "full on");
        x(1'b1, 8'h03, 8'h00);
        x(1'b1, 8'h06, 8'h80);
        x(1'b1, 8'h05, 8'h00);
        x(1'b1, 8'h1D, 8'h01);
        cnt(0);
        chk(n, 128, "duty 80");
        cnt(23);
        chk(n, 1, "duty 01");
        cnt(1);
        chk(n, 0, "duty 00");
        $display("pwm done");
        x(1'b1, 8'h03, 8'hFF);
        undervoltage_lockout = 1'b1;
        repeat (2) @(negedge clk);
        chk(led, 24'h0, "lockout");
        undervoltage_lockout = 1'b0;
        repeat (4) @(negedge clk);
        chk(led, 24'h0, "lockout held");
        x(1'b1, 8'h07, 8'h00);
        @(negedge clk);
        chk({en, led[15:0]}, 17'h15AFF, "rewrite");
        $display("undervoltage done");
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        chk({en, led}, 25'h0, "pin low");
        x(1'b1, 8'h03, 8'hFF);
        x(1'b0, 8'h03, 8'h00);
        chk(v, 1'b0, "no read");
        rst_n = 1'b1;
        @(negedge clk);
        x(1'b0, 8'h03, 8'h00);
        chk({v, q}, 9'h100, "held clear");
        x(1'b1, 8'h03, 8'h01);
        @(negedge clk);
        chk({en, led[0]}, 2'b11, "pin high");
        $display("reset pin done");
        pz = 1'b1;
        @(negedge clk);
        pz = 1'b0;
        x(1'b0, 8'h03, 8'h00);
        chk({v, q}, 9'h100, "power up clear");
        $display("power up done");
        summarize();
    end
endmodule
`default_nettype wire
